/* File: rtl/pirf_irq_flags.sv */
// Second peripheral event flag register with APB access and interrupt.
// Assumes peripheral strobes are on SYS_CLK_IN; comparator output and
// low-voltage detector level arrive asynchronously and are synchronised.
//
// Functional notes
// RULE1: Comparator change sets bit 6, sticky.
// RULE2: Memory write completion sets bit 4, sticky.
// RULE3: Bit 4 zero while writing or idle.
// RULE4: Bus collision sets bit 3 until cleared.
// RULE5: Low voltage sets bit 2, latched.
// RULE6: Bit 2 zero means supply above trip.
// RULE7: Clock switchover sets bit 7; bit 5 zero.
`timescale 1ns/10ps
`include "pirf_params.svh"
module pirf_irq_flags
    import pirf_pkg::*;
(
    input  wire logic        SYS_CLK_IN,
    input  wire logic        SRST_IN,
    // APB slave
    input  wire logic        PSEL_IN,
    input  wire logic        PENABLE_IN,
    input  wire logic        PWRITE_IN,
    input  wire logic [11:0] PADDR_IN,
    input  wire logic [31:0] PWDATA_IN,
    output logic      [31:0] PRDATA_OUT,
    output logic             PREADY_OUT,
    output logic             PSLVERR_OUT,
    // Peripheral events
    input  wire logic        CLK_SWITCH_STB_IN,
    input  wire logic        CMP_LEVEL_IN,
    input  wire logic        NVM_BUSY_IN,
    input  wire logic        NVM_DONE_STB_IN,
    input  wire logic        BUS_COLL_STB_IN,
    input  wire logic        LOW_VOLT_IN,
    input  wire logic        TMR3_OVF_STB_IN,
    input  wire logic        CCP2_EVT_STB_IN,
    // Results
    output logic      [7:0]  FLAGS_OUT,
    output logic             IRQ_OUT
);

    // Bundles to the two flag banks
    pirf_flag_if flags_if ();
    pirf_flag_if stat_if ();

    pirf_apb_state_t state_q;
    pirf_flags_t     mask_q;
    pirf_flags_t     evt_set;
    logic [1:0]      async_sync;
    logic            cmp_prev_q;
    logic            cmp_primed_q;
    logic            cmp_change;
    logic            lv_low;
    logic            cmp_lvl;
    logic            acc_cycle;
    logic            done;
    logic            wr_done;
    logic            rd_done;
    logic            sel_flags;
    logic            sel_mask;
    logic            sel_stat;
    logic            sel_live;
    logic            sel_any;
    logic [31:0]     rd_mux;

    // Asynchronous levels pass two flops before anything reads them
    pirf_sync2 #(
        .W (2)
    ) u_sync (
        .clk_in  (SYS_CLK_IN),
        .srst_in (SRST_IN),
        .d_in    ({LOW_VOLT_IN, CMP_LEVEL_IN}),
        .q_out   (async_sync)
    );

    assign cmp_lvl = async_sync[0];
    assign lv_low  = async_sync[1];

    // Comparator edge detect; primed so the first sample is no change
    always_ff @(posedge SYS_CLK_IN) begin
        if (SRST_IN) begin
            cmp_prev_q   <= 1'b0;
            cmp_primed_q <= 1'b0;
        end else begin
            cmp_prev_q   <= cmp_lvl;
            cmp_primed_q <= 1'b1;
        end
    end

    assign cmp_change = cmp_primed_q & (cmp_lvl ^ cmp_prev_q);

    // Hardware set vector for the flag register
    always_comb begin
        evt_set                         = 8'h00;
        evt_set[`PIRF_BIT_CLK_FAIL]     = CLK_SWITCH_STB_IN; // RULE7
        evt_set[`PIRF_BIT_CMP_CHG]      = cmp_change;        // RULE1
        evt_set[`PIRF_BIT_NVM_DONE]     = NVM_DONE_STB_IN;   // RULE2
        evt_set[`PIRF_BIT_BUS_COLL]     = BUS_COLL_STB_IN;   // RULE4
        // Held while low so a clear cannot hide a standing fault
        evt_set[`PIRF_BIT_LOW_VOLT]     = lv_low;            // RULE5
        evt_set[`PIRF_BIT_TMR3_OVF]     = TMR3_OVF_STB_IN;
        evt_set[`PIRF_BIT_CCP2_EVT]     = CCP2_EVT_STB_IN;
    end

    // APB phase decode
    assign acc_cycle = PSEL_IN & PENABLE_IN;
    assign done      = acc_cycle & (state_q == PIRF_ST_ANSWER);
    assign wr_done   = done & PWRITE_IN;
    assign rd_done   = done & ~PWRITE_IN;

    // Address decode
    always_comb begin
        sel_flags = 1'b0;
        sel_mask  = 1'b0;
        sel_stat  = 1'b0;
        sel_live  = 1'b0;
        if (PADDR_IN == `PIRF_OFS_FLAGS) begin
            sel_flags = 1'b1;
        end else if (PADDR_IN == `PIRF_OFS_MASK) begin
            sel_mask = 1'b1;
        end else if (PADDR_IN == `PIRF_OFS_IRQ_STAT) begin
            sel_stat = 1'b1;
        end else if (PADDR_IN == `PIRF_OFS_LIVE) begin
            sel_live = 1'b1;
        end
    end

    assign sel_any = sel_flags | sel_mask | sel_stat | sel_live;

    // Flag register: software may write either value; bit 5 never stores
    assign flags_if.set   = evt_set & `PIRF_FLAGS_IMPL;  // RULE7
    assign flags_if.clr   = 8'h00;
    assign flags_if.wen   = wr_done & sel_flags;         // RULE3
    assign flags_if.wdata = PWDATA_IN[7:0];

    pirf_flag_bank #(
        .IMPL (`PIRF_FLAGS_IMPL),
        .RST  (`PIRF_FLAGS_RST)
    ) u_flags (
        .clk_in  (SYS_CLK_IN),
        .srst_in (SRST_IN),
        .bus     (flags_if.bank)
    );

    // Interrupt status: one sticky bit per newly raised flag.
    // A read clears only the bits it returned, so a set that lands
    // between capture and completion survives.
    assign stat_if.set   = evt_set & ~flags_if.q & `PIRF_FLAGS_IMPL;
    assign stat_if.clr   = (rd_done & sel_stat) ? PRDATA_OUT[7:0] : 8'h00;
    assign stat_if.wen   = 1'b0;
    assign stat_if.wdata = 8'h00;

    pirf_flag_bank #(
        .IMPL (`PIRF_FLAGS_IMPL),
        .RST  (`PIRF_IRQ_STAT_RST)
    ) u_stat (
        .clk_in  (SYS_CLK_IN),
        .srst_in (SRST_IN),
        .bus     (stat_if.bank)
    );

    // Mask register gates status onto the interrupt line
    always_ff @(posedge SYS_CLK_IN) begin
        if (SRST_IN) begin
            mask_q <= `PIRF_MASK_RST;
        end else if (wr_done && sel_mask) begin
            mask_q <= PWDATA_IN[7:0] & `PIRF_FLAGS_IMPL;
        end
    end

    // Read data mux; bits above the low byte read zero
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (sel_flags) begin
            rd_mux[7:0] = flags_if.q;
        end else if (sel_mask) begin
            rd_mux[7:0] = mask_q;
        end else if (sel_stat) begin
            rd_mux[7:0] = stat_if.q;
        end else if (sel_live) begin
            rd_mux[`PIRF_LIVE_NVM_BUSY] = NVM_BUSY_IN;
            rd_mux[`PIRF_LIVE_LOW_VOLT] = lv_low;
            rd_mux[`PIRF_LIVE_CMP_LVL]  = cmp_lvl;
        end
    end

    // One wait state so every answer comes from a flop
    always_ff @(posedge SYS_CLK_IN) begin
        if (SRST_IN) begin
            state_q <= PIRF_ST_IDLE;
        end else begin
            case (state_q)
                PIRF_ST_IDLE: begin
                    if (acc_cycle) begin
                        state_q <= PIRF_ST_ANSWER;
                    end
                end
                PIRF_ST_ANSWER: begin
                    state_q <= PIRF_ST_IDLE;
                end
                default: begin
                    state_q <= PIRF_ST_IDLE;
                end
            endcase
        end
    end

    // Answer flops: ready, data and error for unmapped addresses
    always_ff @(posedge SYS_CLK_IN) begin
        if (SRST_IN) begin
            PREADY_OUT  <= 1'b0;
            PRDATA_OUT  <= 32'h0000_0000;
            PSLVERR_OUT <= 1'b0;
        end else if (acc_cycle && state_q == PIRF_ST_IDLE) begin
            PREADY_OUT  <= 1'b1;
            PRDATA_OUT  <= PWRITE_IN ? 32'h0000_0000 : rd_mux;
            PSLVERR_OUT <= ~sel_any;
        end else begin
            PREADY_OUT  <= 1'b0;
            PSLVERR_OUT <= 1'b0;
        end
    end

    // Mirror of the flags for neighbouring logic
    always_ff @(posedge SYS_CLK_IN) begin
        if (SRST_IN) begin
            FLAGS_OUT <= `PIRF_FLAGS_RST;
        end else begin
            FLAGS_OUT <= flags_if.q;  // RULE6
        end
    end

    // Level interrupt, one cycle behind the status bits
    always_ff @(posedge SYS_CLK_IN) begin
        if (SRST_IN) begin
            IRQ_OUT <= 1'b0;
        end else begin
            IRQ_OUT <= |(stat_if.q & mask_q);
        end
    end

endmodule : pirf_irq_flags

/* File: rtl/pirf_params.svh */
// Offsets, field positions and reset values of the event flag block.
// Assumes inclusion by bare name from files that need the constants.
`ifndef PIRF_PARAMS_SVH
`define PIRF_PARAMS_SVH

// Register byte offsets on the APB port
`define PIRF_OFS_FLAGS     12'h000
`define PIRF_OFS_MASK      12'h004
`define PIRF_OFS_IRQ_STAT  12'h008
`define PIRF_OFS_LIVE      12'h00c

// Field positions in the event flag register
`define PIRF_BIT_CLK_FAIL  7
`define PIRF_BIT_CMP_CHG   6
`define PIRF_BIT_UNUSED    5
`define PIRF_BIT_NVM_DONE  4
`define PIRF_BIT_BUS_COLL  3
`define PIRF_BIT_LOW_VOLT  2
`define PIRF_BIT_TMR3_OVF  1
`define PIRF_BIT_CCP2_EVT  0

// Field positions in the live status register
`define PIRF_LIVE_NVM_BUSY 0
`define PIRF_LIVE_LOW_VOLT 1
`define PIRF_LIVE_CMP_LVL  2

// Implemented bits and reset values
`define PIRF_FLAGS_IMPL    8'hdf
`define PIRF_FLAGS_RST     8'h00
`define PIRF_MASK_RST      8'h00
`define PIRF_IRQ_STAT_RST  8'h00

`endif

/* File: rtl/pirf_pkg.sv */
// Types shared by the event flag block.
// Assumes constants come from pirf_params.svh.
package pirf_pkg;
    typedef logic [7:0] pirf_flags_t;
    typedef enum logic [0:0] {
        PIRF_ST_IDLE,
        PIRF_ST_ANSWER
    } pirf_apb_state_t;
endpackage : pirf_pkg

/* File: rtl/pirf_flag_if.sv */
// Bundle between the top and one sticky flag bank.
// Assumes one clock domain; all signals are synchronous.
`timescale 1ns/10ps
interface pirf_flag_if;
    import pirf_pkg::*;
    pirf_flags_t set;
    pirf_flags_t clr;
    logic        wen;
    pirf_flags_t wdata;
    pirf_flags_t q;
    modport bank (input set, input clr, input wen, input wdata, output q);
    modport ctrl (output set, output clr, output wen, output wdata, input q);
endinterface : pirf_flag_if

/* File: rtl/pirf_sync2.sv */
// Two-flop synchroniser for levels from outside the clock domain.
// Assumes the input changes slowly compared with the clock.
`timescale 1ns/10ps
module pirf_sync2 #(
    parameter int W = 1
) (
    input  wire logic         clk_in,
    input  wire logic         srst_in,
    input  wire logic [W-1:0] d_in,
    output logic      [W-1:0] q_out
);
    logic [W-1:0] meta_q;

    // First stage feeds only the second stage
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            meta_q <= '0;
            q_out  <= '0;
        end else begin
            meta_q <= d_in;
            q_out  <= meta_q;
        end
    end
endmodule : pirf_sync2

/* File: rtl/pirf_flag_bank.sv */
// Up to eight sticky flags, one per IMPL bit: hardware set, software write or clear.
// Assumes set, clear and write come from the same clock domain.
`timescale 1ns/10ps
module pirf_flag_bank
    import pirf_pkg::*;
#(
    parameter pirf_flags_t IMPL = 8'hff,
    parameter pirf_flags_t RST  = 8'h00
) (
    input  wire logic   clk_in,
    input  wire logic   srst_in,
    pirf_flag_if.bank   bus
);
    genvar i;

    // One flop per implemented bit; a set in the same cycle beats write or clear
    generate
        for (i = 0; i < 8; i++) begin : g_bit
            if (IMPL[i]) begin : g_impl
                logic flag_q;
                logic flag_d;
                always_comb begin
                    flag_d = flag_q & ~bus.clr[i];
                    if (bus.wen) begin
                        flag_d = bus.wdata[i];
                    end
                    flag_d = flag_d | bus.set[i];
                end
                always_ff @(posedge clk_in) begin
                    if (srst_in) begin
                        flag_q <= RST[i];
                    end else begin
                        flag_q <= flag_d;
                    end
                end
                assign bus.q[i] = flag_q;
            end else begin : g_none
                // Unimplemented bit reads zero
                assign bus.q[i] = 1'b0;
            end
        end
    endgenerate
endmodule : pirf_flag_bank

/* File: sim/pirf_checker.sv */
// Port-level assertions for the event flag block.
// Assumes binding to pirf_irq_flags, one clock, sync reset.
`timescale 1ns/10ps
module pirf_checker (
    input wire logic        SYS_CLK_IN,
    input wire logic        SRST_IN,
    input wire logic        PSEL_IN,
    input wire logic        PENABLE_IN,
    input wire logic        PWRITE_IN,
    input wire logic [11:0] PADDR_IN,
    input wire logic        PREADY_OUT,
    input wire logic        PSLVERR_OUT,
    input wire logic        CLK_SWITCH_STB_IN,
    input wire logic        CMP_LEVEL_IN,
    input wire logic        NVM_DONE_STB_IN,
    input wire logic        BUS_COLL_STB_IN,
    input wire logic        LOW_VOLT_IN,
    input wire logic [7:0]  FLAGS_OUT
);
    default clocking cb @(posedge SYS_CLK_IN); endclocking
    default disable iff (SRST_IN);
    // Completed flag write, the only way software drops a flag
    wire wr_f = PSEL_IN & PENABLE_IN & PREADY_OUT & PWRITE_IN & (PADDR_IN == 12'h000);
    a_clk_fail_set: assert property (CLK_SWITCH_STB_IN |=> ##1 FLAGS_OUT[7]) else $error("clk fail flag");
    a_cmp_chg_set: assert property ($changed(CMP_LEVEL_IN) |-> ##[2:5] FLAGS_OUT[6]) else $error("cmp flag");
    a_nvm_done_set: assert property (NVM_DONE_STB_IN |=> ##1 FLAGS_OUT[4]) else $error("nvm flag");
    a_nvm_rise_cause: assert property ($rose(FLAGS_OUT[4]) |->
        $past(NVM_DONE_STB_IN, 2) || $past(wr_f, 2)) else $error("nvm flag no cause");
    a_coll_set: assert property (BUS_COLL_STB_IN |=> ##1 FLAGS_OUT[3]) else $error("coll flag");
    a_low_volt_set: assert property (LOW_VOLT_IN [*5] |-> FLAGS_OUT[2]) else $error("low volt flag");
    a_flag_sticky: assert property (|($past(FLAGS_OUT) & ~FLAGS_OUT) |-> $past(wr_f, 2))
        else $error("flag dropped");
    a_bit5_zero: assert property (FLAGS_OUT[5] == 1'b0) else $error("bit5 set");
    a_ready_wait: assert property (PSEL_IN && !PENABLE_IN |=> !PREADY_OUT ##1 PREADY_OUT) else $error("ready");
    a_ready_pulse: assert property (PREADY_OUT |=> !PREADY_OUT) else $error("ready pulse");
    // Main scenarios reached
    c_coll: cover property (BUS_COLL_STB_IN);
    c_cmp: cover property ($changed(CMP_LEVEL_IN));
    c_err: cover property (PREADY_OUT && PSLVERR_OUT);
endmodule : pirf_checker

bind pirf_irq_flags pirf_checker u_chk (.*);

/* File: sim/pirf_irq_flags_tb.sv */
// Self-checking bench for the event flag block over APB.
// Assumes design ports are matched by name to bench signals.
`timescale 1ns/10ps
`include "pirf_params.svh"
module pirf_irq_flags_tb;
    logic        SYS_CLK_IN = 0, SRST_IN = 1, PSEL_IN = 0, PENABLE_IN = 0, PWRITE_IN = 0;
    logic [11:0] PADDR_IN = 12'h000;
    logic [31:0] PWDATA_IN = 32'h0, rd_q;
    logic        CMP_LEVEL_IN = 0, NVM_BUSY_IN = 0, LOW_VOLT_IN = 0, err_q;
    logic [4:0]  stb = 5'h00;
    wire         CLK_SWITCH_STB_IN, NVM_DONE_STB_IN, BUS_COLL_STB_IN, TMR3_OVF_STB_IN, CCP2_EVT_STB_IN;
    wire  [31:0] PRDATA_OUT;
    wire         PREADY_OUT, PSLVERR_OUT, IRQ_OUT;
    wire  [7:0]  FLAGS_OUT;
    int          err_total = 0, compares = 0;
    int          bits [5] = '{7, 4, 3, 1, 0};
    // Strobe vector order follows the bits table
    assign {CLK_SWITCH_STB_IN, NVM_DONE_STB_IN, BUS_COLL_STB_IN, TMR3_OVF_STB_IN, CCP2_EVT_STB_IN} = stb;
    pirf_irq_flags uut (.*);
    // Clock, 8 ns period
    always #4 SYS_CLK_IN = ~SYS_CLK_IN;
    task chk(input string nm, input logic [31:0] x, input logic [31:0] g);
        compares++;
        if (g !== x) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", nm, x, g);
        end
    endtask : chk
    // Entered just after a rising edge; values read before the edge's updates land
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        PSEL_IN <= 1'b1; PENABLE_IN <= 1'b0; PWRITE_IN <= w; PADDR_IN <= a; PWDATA_IN <= d;
        @(posedge SYS_CLK_IN);
        PENABLE_IN <= 1'b1;
        n = 0;
        do begin
            @(posedge SYS_CLK_IN);
            n++;
        end while (PREADY_OUT !== 1'b1 && n < 20);
        if (n >= 20) chk("pready", 32'h1, 32'h0);
        rd_q = PRDATA_OUT;
        err_q = PSLVERR_OUT;
        PSEL_IN <= 1'b0; PENABLE_IN <= 1'b0;
        @(posedge SYS_CLK_IN);
    endtask : apb
    task rd(input logic [11:0] a, input logic [7:0] x);
        apb(1'b0, a, 32'h0);
        chk("prdata", {24'h0, x}, rd_q);
        chk("pslverr", 32'h0, {31'h0, err_q});
    endtask : rd
    task pulse(input logic [4:0] v);
        stb <= v;
        @(posedge SYS_CLK_IN);
        stb <= 5'h00;
        repeat (3) @(posedge SYS_CLK_IN);
    endtask : pulse
    task finish_test();
        $display("compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : finish_test
    // Main sequence
    initial begin
        repeat (2) @(posedge SYS_CLK_IN);
        SRST_IN <= 1'b0;
        @(posedge SYS_CLK_IN);
        rd(`PIRF_OFS_FLAGS, 8'h00);
        rd(`PIRF_OFS_MASK, 8'h00);
        rd(`PIRF_OFS_IRQ_STAT, 8'h00);
        foreach (bits[i]) begin
            pulse(5'h10 >> i);
            chk("flags_out", 32'h1 << bits[i], {24'h0, FLAGS_OUT});
            rd(`PIRF_OFS_FLAGS, 8'h1 << bits[i]);
            rd(`PIRF_OFS_FLAGS, 8'h1 << bits[i]);
            apb(1'b1, `PIRF_OFS_FLAGS, 32'h0);
            rd(`PIRF_OFS_FLAGS, 8'h00);
        end
        apb(1'b1, `PIRF_OFS_FLAGS, 32'hff);
        rd(`PIRF_OFS_FLAGS, 8'hdf);
        apb(1'b1, `PIRF_OFS_FLAGS, 32'h0);
        // Write in progress keeps the done flag low
        NVM_BUSY_IN <= 1'b1;
        repeat (4) @(posedge SYS_CLK_IN);
        rd(`PIRF_OFS_FLAGS, 8'h00);
        rd(`PIRF_OFS_LIVE, 8'h01);
        NVM_BUSY_IN <= 1'b0;
        pulse(5'h08);
        rd(`PIRF_OFS_FLAGS, 8'h10);
        apb(1'b1, `PIRF_OFS_FLAGS, 32'h0);
        CMP_LEVEL_IN <= 1'b1;
        repeat (6) @(posedge SYS_CLK_IN);
        rd(`PIRF_OFS_FLAGS, 8'h40);
        apb(1'b1, `PIRF_OFS_FLAGS, 32'h0);
        repeat (6) @(posedge SYS_CLK_IN);
        rd(`PIRF_OFS_FLAGS, 8'h00);
        // Clearing cannot win while the supply stays low
        LOW_VOLT_IN <= 1'b1;
        repeat (6) @(posedge SYS_CLK_IN);
        rd(`PIRF_OFS_FLAGS, 8'h04);
        apb(1'b1, `PIRF_OFS_FLAGS, 32'h0);
        rd(`PIRF_OFS_FLAGS, 8'h04);
        LOW_VOLT_IN <= 1'b0;
        repeat (6) @(posedge SYS_CLK_IN);
        apb(1'b1, `PIRF_OFS_FLAGS, 32'h0);
        rd(`PIRF_OFS_FLAGS, 8'h00);
        // Interrupt: masked, unmasked, read-to-clear
        apb(1'b0, `PIRF_OFS_IRQ_STAT, 32'h0);
        pulse(5'h04);
        chk("irq_out", 32'h0, {31'h0, IRQ_OUT});
        apb(1'b1, `PIRF_OFS_MASK, 32'h08);
        repeat (2) @(posedge SYS_CLK_IN);
        chk("irq_out", 32'h1, {31'h0, IRQ_OUT});
        rd(`PIRF_OFS_IRQ_STAT, 8'h08);
        repeat (2) @(posedge SYS_CLK_IN);
        chk("irq_out", 32'h0, {31'h0, IRQ_OUT});
        rd(`PIRF_OFS_IRQ_STAT, 8'h00);
        // Refused and ignored accesses
        apb(1'b0, 12'h010, 32'h0);
        chk("unmapped", 32'h1, {rd_q[30:0], err_q});
        apb(1'b1, `PIRF_OFS_LIVE, 32'hff);
        rd(`PIRF_OFS_LIVE, 8'h04);
        finish_test();
    end
    // Watchdog against a hung handshake
    initial begin
        #20000;
        err_total++;
        finish_test();
    end
endmodule : pirf_irq_flags_tb
